// >>> hdl/rxe_pkg.sv
// Shared constants and types for the receive equaliser control block.
package rxe_pkg;

  // Channel count and table geometry.
  localparam int unsigned NUM_CH      = 2;
  localparam int unsigned TBL_DEPTH   = 16;
  localparam int unsigned STAGE_W     = 2;
  localparam int unsigned NUM_STAGES  = 4;
  localparam int unsigned BOOST_W     = STAGE_W * NUM_STAGES;
  localparam int unsigned EYE_W       = 8;

  // Channel register offsets.
  localparam logic [7:0] REG_STATUS   = 8'h01;
  localparam logic [7:0] REG_BOOST    = 8'h02;
  localparam logic [7:0] REG_CMD      = 8'h0a;
  localparam logic [7:0] REG_LE_GAIN  = 8'h13;
  localparam logic [7:0] REG_SIGDET   = 8'h14;
  localparam logic [7:0] REG_DFE_CTRL = 8'h1e;
  localparam logic [7:0] REG_TAP1     = 8'h21;
  localparam logic [7:0] REG_TAP5     = 8'h25;
  localparam logic [7:0] REG_TBL_LO   = 8'h40;
  localparam logic [7:0] REG_TBL_HI   = 8'h4f;
  localparam logic [7:0] REG_VGA      = 8'h8e;
  localparam logic [7:0] REG_XPOINT   = 8'h96;

  // Field positions.
  localparam int unsigned CMD_READAPT_BIT = 0;
  localparam int unsigned CMD_CDR_RST_BIT = 2;
  localparam int unsigned LE_GAIN_BIT     = 5;
  localparam int unsigned VGA_EN_BIT      = 0;
  localparam int unsigned DFE_AUTO_BIT    = 2;
  localparam int unsigned DFE_CONT_BIT    = 3;
  localparam int unsigned TAP_POL_BIT     = 7;
  localparam int unsigned XPT_EN_BIT      = 0;
  localparam int unsigned XPT_SRC_BIT     = 3;

  // Reset values.
  localparam logic [7:0] TBL_RST      = 8'h00;
  localparam logic       VGA_RST      = 1'b1;
  localparam logic       LE_GAIN_RST  = 1'b0;
  localparam logic [1:0] SIGDET_RST   = 2'h0;
  localparam logic [3:0] DFE_CTRL_RST = 4'h0;
  localparam logic [3:0] XPOINT_RST   = 4'h0;

  // Signal-detect override encodings.
  localparam logic [1:0] SD_AUTO      = 2'h0;
  localparam logic [1:0] SD_FORCE_ON  = 2'h1;
  localparam logic [1:0] SD_FORCE_OFF = 2'h2;

  // Feedback equaliser enable levels and tap masks.
  localparam logic [1:0] DFE_LVL_OFF  = 2'h0;
  localparam logic [1:0] DFE_LVL_TWO  = 2'h1;
  localparam logic [1:0] DFE_LVL_ALL  = 2'h2;
  localparam logic [4:0] TAPS_TWO     = 5'h03;
  localparam logic [4:0] TAPS_ALL     = 5'h1f;

  // Cross-point routing modes.
  localparam logic [1:0] XPT_MUX      = 2'h0;
  localparam logic [1:0] XPT_FANOUT   = 2'h1;
  localparam logic [1:0] XPT_SWAP     = 2'h2;

  // Adaptation sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_APPLY  = 3'b001,
    ST_MEAS   = 3'b010,
    ST_PICK   = 3'b011,
    ST_LOCK   = 3'b100,
    ST_FROZEN = 3'b101
  } rxe_adapt_state_t;

endpackage : rxe_pkg

// >>> hdl/rxe_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/100ps
module rxe_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rxe_sync_st_t;

  rxe_sync_st_t st_q;
  rxe_sync_st_t st_d;

  // A bit only moves once the second and third stages agree.
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.out;

endmodule : rxe_sync

// >>> hdl/rxe_adapt.sv
// Linear equaliser boost search and freeze sequencer for one channel.
`timescale 1ns/100ps
module rxe_adapt (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_path_on,
  input  wire logic                     i_lock,
  input  wire logic                     i_restart,
  input  wire logic [16*8-1:0]          i_table,
  input  wire logic                     i_eye_valid,
  input  wire logic [7:0]               i_heo,
  input  wire logic [7:0]               i_veo,
  output logic      [7:0]               o_boost,
  output logic                          o_meas_req,
  output logic                          o_acquiring,
  output logic      [3:0]               o_idx,
  output logic      [2:0]               o_state
);

  typedef struct packed {
    rxe_pkg::rxe_adapt_state_t state;
    logic [3:0] idx;
    logic [3:0] best_idx;
    logic [8:0] best_fom;
    logic [7:0] boost;
    logic       meas_req;
  } rxe_adapt_st_t;

  rxe_adapt_st_t st_q;
  rxe_adapt_st_t st_d;
  logic [8:0]    figure_of_merit_score;

  // Score is the sum of eye width and height.
  assign figure_of_merit_score = {1'b0, i_heo} + {1'b0, i_veo};

  // Walk the table, keep the best score, apply it and freeze on lock.
  always_comb
  begin
    st_d          = st_q;
    st_d.meas_req = 1'b0;
    case (st_q.state)
      rxe_pkg::ST_IDLE:
      begin
        st_d.state = rxe_pkg::ST_APPLY;
        st_d.idx   = 4'h0;
      end
      rxe_pkg::ST_APPLY:
      begin
        st_d.boost    = i_table[{st_q.idx, 3'b000} +: 8];
        st_d.meas_req = 1'b1;
        st_d.state    = rxe_pkg::ST_MEAS;
      end
      rxe_pkg::ST_MEAS:
      begin
        if (i_eye_valid)
        begin
          if (st_q.idx == 4'h0 || figure_of_merit_score > st_q.best_fom)
          begin
            st_d.best_fom = figure_of_merit_score;
            st_d.best_idx = st_q.idx;
          end
          if (st_q.idx == 4'hf)
          begin
            st_d.state = rxe_pkg::ST_PICK;
          end
          else
          begin
            st_d.idx   = st_q.idx + 4'h1;
            st_d.state = rxe_pkg::ST_APPLY;
          end
        end
      end
      rxe_pkg::ST_PICK:
      begin
        st_d.idx   = st_q.best_idx;
        st_d.boost = i_table[{st_q.best_idx, 3'b000} +: 8];
        st_d.state = rxe_pkg::ST_LOCK;
      end
      rxe_pkg::ST_LOCK:
      begin
        if (i_lock)
        begin
          st_d.state = rxe_pkg::ST_FROZEN;
        end
      end
      rxe_pkg::ST_FROZEN:
      begin
        // Losing lock means acquisition restarts, so the search reruns.
        if (!i_lock)
        begin
          st_d.idx   = 4'h0;
          st_d.state = rxe_pkg::ST_APPLY;
        end
      end
      default:
      begin
        st_d.state = rxe_pkg::ST_IDLE;
      end
    endcase
    // Host command and a loop reset both start a fresh search.
    if (i_restart)
    begin
      st_d.idx   = 4'h0;
      st_d.state = rxe_pkg::ST_APPLY;
    end
    if (!i_path_on)
    begin
      st_d.state = rxe_pkg::ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      st_q <= '{state: rxe_pkg::ST_IDLE, default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_boost     = st_q.boost;
  assign o_meas_req  = st_q.meas_req;
  assign o_acquiring = (st_q.state != rxe_pkg::ST_IDLE)
                    && (st_q.state != rxe_pkg::ST_FROZEN);
  assign o_idx       = st_q.idx;
  assign o_state     = st_q.state;

endmodule : rxe_adapt

// >>> hdl/rxe_ctrl.sv
// Receive conditioning control for both channels of the retimer.
//
// Behaviour
// - Two channels, independent control except the shared cross-point register.
// - Signal detect powers data path by default.
// - Host may override signal-detect gating per channel.
// - Boost chosen by eye width plus height.
// - Boost frozen after lock until re-adapt.
// - Loop reset starts a fresh adaptation.
// - Boost is four two-bit stage fields.
// - Search only the sixteen table entries.
// - Gain stage enable bit, on at reset.
// - Separate linear equaliser DC gain bit.
// - Cross-point does mux, fanout and swap.
// - Feedback equaliser off until host enables.
// - Feedback adapts at acquisition or continuously.
// - Enable levels all taps, two, none.
// - Unit-spaced taps with weight and polarity.
// - Tap one 0-31, others 0-15.
// - Polarity 0 positive, 1 negative feedback.
`timescale 1ns/100ps
module rxe_ctrl (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Decoded channel-register access.
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_chan,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // Analogue status pins, asynchronous.
  input  wire logic [1:0]  i_sig_det,
  input  wire logic [1:0]  i_cdr_lock,
  // Eye monitor results, core clock domain.
  input  wire logic [1:0]  i_eye_valid,
  input  wire logic [15:0] i_heo,
  input  wire logic [15:0] i_veo,
  // Controls to the analogue path.
  output logic      [1:0]  o_path_on,
  output logic      [1:0]  o_meas_req,
  output logic      [15:0] o_boost,
  output logic      [1:0]  o_vga_en,
  output logic      [1:0]  o_le_gain,
  output logic      [1:0]  o_cdr_reset,
  output logic      [1:0]  o_xpt_en,
  output logic      [1:0]  o_xpt_src,
  output logic      [9:0]  o_dfe_tap_en,
  output logic      [1:0]  o_dfe_adapt,
  output logic      [9:0]  o_dfe_tap1_wt,
  output logic      [31:0] o_dfe_tapn_wt,
  output logic      [9:0]  o_dfe_pol
);

  localparam int unsigned NCH = rxe_pkg::NUM_CH;

  typedef struct packed {
    logic [NCH-1:0][15:0][7:0] tbl;
    logic [NCH-1:0]            vga;
    logic [NCH-1:0]            le_gain;
    logic [NCH-1:0][1:0]       sd_mode;
    logic [NCH-1:0][3:0]       dfe_ctrl;
    logic [NCH-1:0][4:0]       tap1;
    logic [NCH-1:0][3:0][3:0]  tapn;
    logic [NCH-1:0][4:0]       pol;
    logic [3:0]                xpt;
    logic [NCH-1:0]            restart;
    logic [NCH-1:0]            cdr_rst;
    logic [NCH-1:0]            path_on;
    logic [NCH-1:0][4:0]       tap_en;
    logic [NCH-1:0]            dfe_adapt;
    logic [NCH-1:0]            xpt_en;
    logic [NCH-1:0]            xpt_src;
    logic [7:0]                rdata;
    logic                      rvalid;
  } rxe_ctrl_st_t;

  rxe_ctrl_st_t     st_q;
  rxe_ctrl_st_t     st_d;
  logic [NCH-1:0]   sd_sync;
  logic [NCH-1:0]   lock_sync;
  logic [NCH-1:0]   acquiring;
  logic [NCH-1:0][7:0] boost;
  logic [NCH-1:0][3:0] ad_idx;
  logic [NCH-1:0][2:0] ad_state;
  logic [NCH-1:0]   meas_req;

  // Both status pins cross into the core clock through one filter each.
  rxe_sync #(
    .W (2 * NCH)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_cdr_lock, i_sig_det}),
    .o_sync     ({lock_sync, sd_sync})
  );

  // One adaptation sequencer per channel, sharing nothing.
  for (genvar c = 0; c < NCH; c++)
  begin : g_adapt
    rxe_adapt u_adapt (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_path_on   (st_q.path_on[c]),
      .i_lock      (lock_sync[c]),
      .i_restart   (st_q.restart[c] | st_q.cdr_rst[c]),
      .i_table     (st_q.tbl[c]),
      .i_eye_valid (i_eye_valid[c]),
      .i_heo       (i_heo[c*8 +: 8]),
      .i_veo       (i_veo[c*8 +: 8]),
      .o_boost     (boost[c]),
      .o_meas_req  (meas_req[c]),
      .o_acquiring (acquiring[c]),
      .o_idx       (ad_idx[c]),
      .o_state     (ad_state[c])
    );
  end

  // Register writes, derived controls and read-back.
  always_comb
  begin
    logic       ch;
    logic [3:0] ti;
    logic [2:0] tn;
    ch           = i_reg_chan;
    ti           = i_reg_addr[3:0];
    tn           = 3'(i_reg_addr - rxe_pkg::REG_TAP1);
    st_d         = st_q;
    st_d.restart = '0;
    st_d.cdr_rst = '0;
    st_d.rvalid  = i_reg_rd;
    st_d.rdata   = 8'h00;
    if (i_reg_wr)
    begin
      if (i_reg_addr >= rxe_pkg::REG_TBL_LO
          && i_reg_addr <= rxe_pkg::REG_TBL_HI)
      begin
        st_d.tbl[ch][ti] = i_reg_wdata;
      end
      else if (i_reg_addr >= rxe_pkg::REG_TAP1
               && i_reg_addr <= rxe_pkg::REG_TAP5)
      begin
        // Taps are taken as written; auto-adapt must be off first.
        st_d.pol[ch][tn] = i_reg_wdata[rxe_pkg::TAP_POL_BIT];
        if (tn == 3'h0)
        begin
          st_d.tap1[ch] = i_reg_wdata[4:0];
        end
        else
        begin
          st_d.tapn[ch][2'(tn - 3'h1)] = i_reg_wdata[3:0];
        end
      end
      else
      begin
        case (i_reg_addr)
          rxe_pkg::REG_CMD:
          begin
            st_d.restart[ch] = i_reg_wdata[rxe_pkg::CMD_READAPT_BIT];
            st_d.cdr_rst[ch] = i_reg_wdata[rxe_pkg::CMD_CDR_RST_BIT];
          end
          rxe_pkg::REG_LE_GAIN:
          begin
            st_d.le_gain[ch] = i_reg_wdata[rxe_pkg::LE_GAIN_BIT];
          end
          rxe_pkg::REG_VGA:
          begin
            st_d.vga[ch] = i_reg_wdata[rxe_pkg::VGA_EN_BIT];
          end
          rxe_pkg::REG_SIGDET:
          begin
            st_d.sd_mode[ch] = i_reg_wdata[1:0];
          end
          rxe_pkg::REG_DFE_CTRL:
          begin
            st_d.dfe_ctrl[ch] = i_reg_wdata[3:0];
          end
          rxe_pkg::REG_XPOINT:
          begin
            st_d.xpt = i_reg_wdata[3:0];
          end
          default:
          begin
            st_d.rvalid = i_reg_rd;
          end
        endcase
      end
    end

    // Per-channel gating and feedback equaliser controls.
    for (int c = 0; c < NCH; c++)
    begin
      case (st_q.sd_mode[c])
        rxe_pkg::SD_FORCE_ON:  st_d.path_on[c] = 1'b1;
        rxe_pkg::SD_FORCE_OFF: st_d.path_on[c] = 1'b0;
        default:               st_d.path_on[c] = sd_sync[c];
      endcase
      case (st_q.dfe_ctrl[c][1:0])
        rxe_pkg::DFE_LVL_ALL: st_d.tap_en[c] = rxe_pkg::TAPS_ALL;
        rxe_pkg::DFE_LVL_TWO: st_d.tap_en[c] = rxe_pkg::TAPS_TWO;
        default:              st_d.tap_en[c] = 5'h00;
      endcase
      // Adapts only when taps are on, auto mode set, and in its window.
      // Level code 3 also means no taps, so it must not enable adaptation.
      st_d.dfe_adapt[c] = ((st_q.dfe_ctrl[c][1:0] == rxe_pkg::DFE_LVL_TWO)
          || (st_q.dfe_ctrl[c][1:0] == rxe_pkg::DFE_LVL_ALL))
        && st_q.dfe_ctrl[c][rxe_pkg::DFE_AUTO_BIT]
        && (st_q.dfe_ctrl[c][rxe_pkg::DFE_CONT_BIT] || acquiring[c]);
    end

    // Cross-point: lane n output takes data from channel xpt_src[n].
    st_d.xpt_en  = {NCH{st_q.xpt[rxe_pkg::XPT_EN_BIT]}};
    st_d.xpt_src = 2'b10;
    if (st_q.xpt[rxe_pkg::XPT_EN_BIT])
    begin
      case (st_q.xpt[2:1])
        rxe_pkg::XPT_MUX:
          st_d.xpt_src[0] = st_q.xpt[rxe_pkg::XPT_SRC_BIT];
        rxe_pkg::XPT_FANOUT:
          st_d.xpt_src = {2{st_q.xpt[rxe_pkg::XPT_SRC_BIT]}};
        rxe_pkg::XPT_SWAP:
          st_d.xpt_src = 2'b01;
        default:
          st_d.xpt_src = 2'b10;
      endcase
    end

    // Read-back; unmapped offsets and command bits read as zero.
    if (i_reg_rd)
    begin
      if (i_reg_addr >= rxe_pkg::REG_TBL_LO
          && i_reg_addr <= rxe_pkg::REG_TBL_HI)
      begin
        st_d.rdata = st_q.tbl[ch][ti];
      end
      else if (i_reg_addr >= rxe_pkg::REG_TAP1
               && i_reg_addr <= rxe_pkg::REG_TAP5)
      begin
        st_d.rdata[rxe_pkg::TAP_POL_BIT] = st_q.pol[ch][tn];
        if (tn == 3'h0)
        begin
          st_d.rdata[4:0] = st_q.tap1[ch];
        end
        else
        begin
          st_d.rdata[3:0] = st_q.tapn[ch][2'(tn - 3'h1)];
        end
      end
      else
      begin
        case (i_reg_addr)
          rxe_pkg::REG_STATUS:
            st_d.rdata = {st_q.path_on[ch], ad_idx[ch], ad_state[ch]};
          rxe_pkg::REG_BOOST:
            st_d.rdata = boost[ch];
          rxe_pkg::REG_LE_GAIN:
            st_d.rdata[rxe_pkg::LE_GAIN_BIT] = st_q.le_gain[ch];
          rxe_pkg::REG_VGA:
            st_d.rdata[rxe_pkg::VGA_EN_BIT] = st_q.vga[ch];
          rxe_pkg::REG_SIGDET:
            st_d.rdata[1:0] = st_q.sd_mode[ch];
          rxe_pkg::REG_DFE_CTRL:
            st_d.rdata[3:0] = st_q.dfe_ctrl[ch];
          rxe_pkg::REG_XPOINT:
            st_d.rdata[3:0] = st_q.xpt;
          default:
            st_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register; the table resets to a plain default pattern.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      st_q          <= '0;
      st_q.tbl      <= {(NCH * 16){rxe_pkg::TBL_RST}};
      st_q.vga      <= {NCH{rxe_pkg::VGA_RST}};
      st_q.le_gain  <= {NCH{rxe_pkg::LE_GAIN_RST}};
      st_q.sd_mode  <= {NCH{rxe_pkg::SIGDET_RST}};
      st_q.dfe_ctrl <= {NCH{rxe_pkg::DFE_CTRL_RST}};
      st_q.xpt      <= rxe_pkg::XPOINT_RST;
      st_q.xpt_src  <= 2'b10;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops.
  assign o_reg_rdata  = st_q.rdata;
  assign o_reg_rvalid = st_q.rvalid;
  assign o_path_on    = st_q.path_on;
  assign o_meas_req   = meas_req;
  assign o_boost      = boost;
  assign o_vga_en     = st_q.vga;
  assign o_le_gain    = st_q.le_gain;
  assign o_cdr_reset  = st_q.cdr_rst;
  assign o_xpt_en     = st_q.xpt_en;
  assign o_xpt_src    = st_q.xpt_src;
  assign o_dfe_tap_en = st_q.tap_en;
  assign o_dfe_adapt  = st_q.dfe_adapt;
  assign o_dfe_tap1_wt = st_q.tap1;
  assign o_dfe_tapn_wt = st_q.tapn;
  assign o_dfe_pol    = st_q.pol;

endmodule : rxe_ctrl

// >>> verification/rxe_ctrl_chk.sv
// Port-level assertion checker for the receive equaliser control block.
`timescale 1ns/100ps
module rxe_ctrl_chk (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic       i_reg_chan,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic [7:0] o_reg_rdata,
  input  wire logic       o_reg_rvalid,
  input  wire logic [1:0] o_path_on,
  input  wire logic [1:0] o_meas_req,
  input  wire logic [1:0] o_vga_en,
  input  wire logic [1:0] o_cdr_reset,
  input  wire logic [1:0] o_xpt_en,
  input  wire logic [1:0] o_xpt_src,
  input  wire logic [9:0] o_dfe_tap_en,
  input  wire logic [1:0] o_dfe_adapt
);
  // Channel 0 write decode keeps the properties short.
  logic wr0;
  assign wr0 = i_reg_wr && !i_reg_chan;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Reset is checked with no disable, since it is the cause itself.
  rst_values_a: assert property (disable iff (1'b0) !i_rst_n |=>
    o_vga_en == 2'b11 && o_xpt_src == 2'b10 && o_dfe_tap_en == '0
    && o_path_on == 2'b00) else $error("reset values wrong");
  read_answer_a: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read answer not one cycle after strobe");
  unmapped_zero_a: assert property (i_reg_rd && i_reg_addr == 8'h00
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  vga_write_a: assert property (wr0 && i_reg_addr == rxe_pkg::REG_VGA
    |=> o_vga_en[0] == $past(i_reg_wdata[0])) else $error("gain bit lost");
  loop_pulse_a: assert property (wr0 && i_reg_addr == rxe_pkg::REG_CMD
    && i_reg_wdata[2] |=> o_cdr_reset[0] ##1 !o_cdr_reset[0])
    else $error("loop reset pulse wrong");
  readapt_go_a: assert property (wr0 && i_reg_addr == rxe_pkg::REG_CMD
    && i_reg_wdata[0] && o_path_on[0] |-> ##[2:4] o_meas_req[0])
    else $error("re-adapt did not start a measurement");
  meas_pulse_a: assert property (o_meas_req[0] |=> !o_meas_req[0])
    else $error("measurement request longer than one cycle");
  force_off_a: assert property (wr0 && i_reg_addr == rxe_pkg::REG_SIGDET
    && i_reg_wdata[1:0] == rxe_pkg::SD_FORCE_OFF |-> ##[1:3] !o_path_on[0])
    else $error("forced off path still powered");
  adapt_taps_a: assert property (o_dfe_adapt[1] |-> o_dfe_tap_en[9:5] != 0)
    else $error("feedback adapting with no taps");
  tap_levels_a: assert property (o_dfe_tap_en[9:5] inside
    {5'h00, 5'h03, 5'h1f}) else $error("illegal tap enable pattern");
  xpt_pair_a: assert property (o_xpt_en[0] == o_xpt_en[1])
    else $error("cross-point enables disagree");
endmodule : rxe_ctrl_chk

bind rxe_ctrl rxe_ctrl_chk i_chk (.*);

// >>> verification/rxe_eye_model.sv
// Behavioural eye monitor answering measurement requests on both channels.
`timescale 1ns/100ps
module rxe_eye_model #(
  parameter int unsigned DLY0 = 2,
  parameter int unsigned DLY1 = 9
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_meas_req,
  input  wire logic [15:0] i_boost,
  output logic      [1:0]  o_eye_valid,
  output logic      [15:0] o_heo,
  output logic      [15:0] o_veo
);
  int unsigned cnt [2];

  // Width equals the applied boost, so the largest table value wins.
  // Results toggle between answers so a stale value is never mistaken.
  always @(posedge i_core_clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      o_eye_valid[c] <= 1'b0;
      o_heo[c*8+:8] <= ~o_heo[c*8+:8];
      o_veo[c*8+:8] <= ~o_veo[c*8+:8];
      if (!i_rst_n)
      begin
        cnt[c] <= 0;
        o_heo[c*8+:8] <= 8'h00;
        o_veo[c*8+:8] <= 8'h00;
      end
      else if (i_meas_req[c])
        cnt[c] <= c ? DLY1 : DLY0;
      else if (cnt[c] != 0)
      begin
        cnt[c] <= cnt[c] - 1;
        if (cnt[c] == 1)
        begin
          o_eye_valid[c] <= 1'b1;
          o_heo[c*8+:8] <= i_boost[c*8+:8];
          o_veo[c*8+:8] <= 8'h10;
        end
      end
    end
  end
endmodule : rxe_eye_model

// >>> verification/tb_rxe_ctrl.sv
// Self-checking bench for the receive equaliser control block.
`timescale 1ns/100ps
module tb_rxe_ctrl;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        i_reg_chan = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic [1:0]  i_sig_det = 2'h0;
  logic [1:0]  i_cdr_lock = 2'h0;
  logic [1:0]  i_eye_valid, o_path_on, o_meas_req, o_vga_en, o_le_gain;
  logic [1:0]  o_cdr_reset, o_xpt_en, o_xpt_src, o_dfe_adapt;
  logic [15:0] i_heo, i_veo, o_boost;
  logic [9:0]  o_dfe_tap_en, o_dfe_tap1_wt, o_dfe_pol;
  logic [31:0] o_dfe_tapn_wt;
  logic [7:0]  o_reg_rdata, rd_q;
  logic        o_reg_rvalid;
  logic [1:0]  xs [6] = '{2'b10, 2'b11, 2'b00, 2'b11, 2'b01, 2'b01};
  logic [4:0]  lv [4] = '{5'h00, 5'h03, 5'h1f, 5'h00};
  logic [7:0]  sd = 8'hb2;
  int          failures = 0;
  int          tests_run = 0;

  always #2 i_core_clk = ~i_core_clk;

  rxe_ctrl i_dut (.*);

  rxe_eye_model i_eye (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_meas_req  (o_meas_req),
    .i_boost     (o_boost),
    .o_eye_valid (i_eye_valid),
    .o_heo       (i_heo),
    .o_veo       (i_veo)
  );

  task automatic finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ends at a falling edge so registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : cyc

  task automatic wr(input logic ch, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_wr    <= 1'b1;
    i_reg_chan  <= ch;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  // Data counts only when the valid pulse is present.
  task automatic rd(input logic ch, input logic [7:0] a);
    @(posedge i_core_clk);
    i_reg_rd   <= 1'b1;
    i_reg_chan <= ch;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    rd_q = o_reg_rvalid ? o_reg_rdata : 8'hxx;
  endtask : rd

  task automatic rdc(input logic ch, input logic [7:0] a, input logic [7:0] e);
    rd(ch, a);
    chk(rd_q, e);
  endtask : rdc

  // Polls the status register; a run that never freezes ends the test.
  task automatic wait_frozen(input logic ch);
    int k;
    cyc(4);
    for (k = 0; k < 400; k++)
    begin
      rd(ch, rxe_pkg::REG_STATUS);
      if (rd_q[2:0] === rxe_pkg::ST_FROZEN)
        break;
    end
    if (k == 400)
    begin
      failures++;
      finish_test();
    end
  endtask : wait_frozen

  // Each channel has its best entry at a different index.
  function automatic logic [7:0] tv(input int ch, input int i);
    if (ch == 0)
      return (i == 9) ? 8'hd2 : 8'(i);
    return (i == 4) ? 8'he7 : 8'(i + 32);
  endfunction : tv

  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rdc(0, rxe_pkg::REG_VGA, 8'h01);
    rdc(1, rxe_pkg::REG_LE_GAIN, 8'h00);
    rdc(1, rxe_pkg::REG_DFE_CTRL, 8'h00);
    rdc(0, 8'h00, 8'h00);
    chk(o_dfe_tap_en, 10'h000);
    // Tables are loaded while no signal is present.
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 16; i++)
        wr(c[0], rxe_pkg::REG_TBL_LO + 8'(i), tv(c, i));
    rdc(1, rxe_pkg::REG_TBL_HI, tv(1, 15));
    @(posedge i_core_clk);
    i_sig_det  <= 2'b11;
    i_cdr_lock <= 2'b11;
    wait_frozen(0);
    wait_frozen(1);
    chk(o_boost, {8'he7, 8'hd2});
    rdc(0, rxe_pkg::REG_BOOST, 8'hd2);
    // A new table value must not move a frozen boost until re-adapt.
    wr(0, rxe_pkg::REG_TBL_LO + 8'h03, 8'hfe);
    cyc(60);
    chk(o_boost[7:0], 8'hd2);
    wr(0, rxe_pkg::REG_CMD, 8'h01);
    wait_frozen(0);
    chk(o_boost, {8'he7, 8'hfe});
    wr(0, rxe_pkg::REG_TBL_LO + 8'h03, 8'h03);
    wr(0, rxe_pkg::REG_CMD, 8'h04);
    wait_frozen(0);
    chk(o_boost[7:0], 8'hd2);
    wr(0, rxe_pkg::REG_VGA, 8'h00);
    wr(1, rxe_pkg::REG_LE_GAIN, 8'h20);
    cyc(2);
    chk(o_vga_en, 2'b10);
    chk(o_le_gain, 2'b10);
    // Every routing mode with each source, written through both channels.
    for (int m = 0; m < 6; m++)
    begin
      wr(m[0], rxe_pkg::REG_XPOINT, 8'(m / 2 * 2 + 1 + m % 2 * 8));
      cyc(2);
      chk(o_xpt_en, 2'b11);
      chk(o_xpt_src, xs[m]);
    end
    wr(0, rxe_pkg::REG_XPOINT, 8'h00);
    cyc(2);
    chk({o_xpt_en, o_xpt_src}, 4'h2);
    // Every level with auto and continuous adaptation requested.
    for (int l = 0; l < 4; l++)
    begin
      wr(1, rxe_pkg::REG_DFE_CTRL, 8'(l + 12));
      cyc(2);
      chk(o_dfe_tap_en[9:5], lv[l]);
      chk(o_dfe_adapt[1], l == 1 || l == 2);
    end
    wr(1, rxe_pkg::REG_DFE_CTRL, 8'h06);
    cyc(2);
    chk(o_dfe_adapt[1], 1'b0);
    wr(1, rxe_pkg::REG_DFE_CTRL, 8'h02);
    wr(1, rxe_pkg::REG_TAP1, 8'h9f);
    for (int t = 2; t < 6; t++)
      wr(1, rxe_pkg::REG_TAP1 + 8'(t - 1), 8'(t % 2 * 128 + 15 - t));
    cyc(2);
    chk(o_dfe_tap1_wt[9:5], 5'h1f);
    chk(o_dfe_tapn_wt[31:16], 16'habcd);
    chk(o_dfe_pol[9:5], 5'h15);
    chk(o_dfe_tap_en[9:5], 5'h1f);
    // Each override mode with the pin low, then high; channel 1 stays up.
    for (int p = 0; p < 8; p++)
    begin
      @(posedge i_core_clk);
      i_sig_det[0] <= p[2];
      wr(0, rxe_pkg::REG_SIGDET, 8'(p % 4));
      cyc(8);
      chk(o_path_on, {1'b1, sd[p]});
    end
    finish_test();
  end
endmodule : tb_rxe_ctrl
